/* core/ufp_fault_ctrl.sv */
`timescale 1ns/1ps
// Operation
// - current sense output enabled only in normal power mode
// - bus over-current protection active only in normal mode, both paths
// - bus over-current detected in sink and source directions
// - any over-current turns off supply switches, channel switches, gate drivers
// - alarm held 40 us after over-current; recovery ignored meanwhile
// - after hold, channel switches back on; supply switches and gates stay off
// - restart only after recovery word over serial bus, never automatically
// - fault flag held low after over-current until recovery word written
// - bus over-current activates supply and bus discharge, channel lines back on after hold
// - acknowledge bits of shut switches are cleared on over-current
// - flag bit naming over-current source is set
// - recovery word 00 pm 1000, same for bus and supply faults
// - supply start-up uses raised trip level for 512 us to 1 ms
// - after soft start, supply trip level returns to normal 50 mA
// - channel over-voltage engages line protection, flag pin low quickly
// - channel over-voltage gone: protection released, flag released automatically
// - bus discharge only by command, except the over-current response
// - supply discharge refused while either supply switch is closed
// - supply discharge applied to the channel pin last carrying supply
// - over-temperature asserts flag and shuts protections and switches
// - over-temperature clears: operation resumes automatically
// - normal mode flag signals error; master reads status to identify it
// - hibernate and low power modes: flag shows bus voltage presence
module ufp_fault_ctrl
#(
  parameter int unsigned HOLD_CYC = ufp_pkg::OC_HOLD_CYC,
  parameter int unsigned SOFT_CYC = ufp_pkg::SOFT_START_CYC
)
(
  // system
  input wire logic ref_clk,
  input wire logic resetn,
  // serial-bus clock domain: control byte writes
  input wire logic link_clk,
  input wire logic link_resetn,
  input wire logic ctl_wr_stb,
  input wire logic [7:0] ctl_wr_data,
  // analog comparator inputs (asynchronous)
  input wire logic bus_oc_sink,
  input wire logic bus_oc_source,
  input wire logic supply_oc_normal,
  input wire logic supply_oc_soft,
  input wire logic cc_overvoltage,
  input wire logic over_temp,
  input wire logic bus_present,
  // power stage controls
  output logic cc1_supply_sw_on,
  output logic cc2_supply_sw_on,
  output logic provider_gate_on,
  output logic consumer_gate_on,
  output logic cc_switch_on,
  output logic cc_line_protect,
  output logic bus_discharge_on,
  output logic cc1_supply_discharge_on,
  output logic cc2_supply_discharge_on,
  output logic current_sense_en,
  output logic supply_soft_start,
  // open-drain fault flag
  output logic fault_flag_pin_o,
  output logic fault_flag_pin_oe,
  // readable status
  output logic cc1_supply_switch_ack,
  output logic cc2_supply_switch_ack,
  output logic provider_gate_ack,
  output logic consumer_gate_ack,
  output logic power_mode_bit_low,
  output logic power_mode_bit_high,
  output logic bus_discharge_ack,
  output logic supply_discharge_ack,
  output logic bus_overcurrent_flag,
  output logic supply_overcurrent_flag,
  output logic cc_overvoltage_flag,
  output logic over_temp_flag,
  output logic oc_hold_active
);
  import ufp_pkg::*;

  // ******************************************************************
  // link domain: capture written byte, toggle per write
  // ******************************************************************
  logic [7:0] link_data_q;
  logic link_tog_q;

  always_ff @(posedge link_clk)
  begin
    if (!link_resetn)
    begin
      link_data_q <= CTL_RESET;
      link_tog_q <= 1'b0;
    end
    else if (ctl_wr_stb)
    begin
      link_data_q <= ctl_wr_data;
      link_tog_q <= ~link_tog_q;
    end
  end

  // ******************************************************************
  // synchronisers
  // ******************************************************************
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic tog3_q;
  logic [7:0] wr_byte_q;

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      tog3_q <= 1'b0;
    end
    else
    begin
      s1_q <= {link_tog_q, bus_oc_sink, bus_oc_source, supply_oc_normal,
               supply_oc_soft, cc_overvoltage, over_temp, bus_present};
      s2_q <= s1_q;
      tog3_q <= s2_q[7];
    end
  end

  // data stable long before the toggle arrives, so sample it on the event
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      wr_byte_q <= CTL_RESET;
    else if (s2_q[7] != tog3_q)
      wr_byte_q <= link_data_q;
  end

  logic wr_ev_q;
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      wr_ev_q <= 1'b0;
    else
      wr_ev_q <= (s2_q[7] != tog3_q);
  end

  logic bus_oc_s;
  logic sup_oc_norm_s;
  logic sup_oc_soft_s;
  logic cc_ov_s;
  logic ot_s;
  logic present_s;
  assign bus_oc_s = s2_q[6] | s2_q[5];
  assign sup_oc_norm_s = s2_q[4];
  assign sup_oc_soft_s = s2_q[3];
  assign cc_ov_s = s2_q[2];
  assign ot_s = s2_q[1];
  assign present_s = s2_q[0];

  function automatic logic is_recovery(input logic [7:0] b);
    is_recovery = (b & RECOVERY_MASK) == RECOVERY_VALUE;
  endfunction

  // ******************************************************************
  // control register
  // ******************************************************************
  logic [7:0] ctl_q;
  ufp_pm_t pm;
  logic normal;
  assign pm = ufp_pm_t'(ctl_q[CTL_PM_HI_BIT:CTL_PM_LO_BIT]);
  assign normal = (pm == UFP_PM_NORMAL);

  ufp_state_t st_q;
  logic [CNT_W-1:0] hold_cnt_q;
  logic wr_accept;
  assign wr_accept = wr_ev_q && (st_q != UFP_ST_HOLD);

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      ctl_q <= CTL_RESET;
    else if (wr_accept)
      ctl_q <= wr_byte_q;
  end

  // ******************************************************************
  // over-current detection
  // ******************************************************************
  logic sup_on;
  logic soft_q;
  logic [CNT_W-1:0] soft_cnt_q;
  logic sup_on_prev_q;
  logic bus_oc_ev;
  logic sup_oc_ev;
  assign sup_on = ctl_q[CTL_SW1_BIT] ^ ctl_q[CTL_SW2_BIT];
  assign bus_oc_ev = normal && bus_oc_s;
  assign sup_oc_ev = sup_on && (soft_q ? sup_oc_soft_s : sup_oc_norm_s);

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      soft_q <= 1'b0;
      soft_cnt_q <= '0;
      sup_on_prev_q <= 1'b0;
    end
    else
    begin
      sup_on_prev_q <= sup_on && (st_q == UFP_ST_RUN);
      if (sup_on && (st_q == UFP_ST_RUN) && !sup_on_prev_q)
      begin
        soft_q <= 1'b1;
        soft_cnt_q <= '0;
      end
      else if (soft_q)
      begin
        if (soft_cnt_q == CNT_W'(SOFT_CYC - 1))
          soft_q <= 1'b0;
        soft_cnt_q <= soft_cnt_q + 1'b1;
      end
    end
  end

  // ******************************************************************
  // fault state machine
  // ******************************************************************
  logic bus_src_q;
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      st_q <= UFP_ST_RUN;
      hold_cnt_q <= '0;
      bus_src_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        UFP_ST_RUN:
        begin
          if (bus_oc_ev || sup_oc_ev)
          begin
            st_q <= UFP_ST_HOLD;
            hold_cnt_q <= '0;
            bus_src_q <= bus_oc_ev;
          end
        end
        UFP_ST_HOLD:
        begin
          hold_cnt_q <= hold_cnt_q + 1'b1;
          if (hold_cnt_q == CNT_W'(HOLD_CYC - 1))
            st_q <= UFP_ST_LATCHED;
        end
        UFP_ST_LATCHED:
        begin
          if (wr_ev_q && is_recovery(wr_byte_q))
            st_q <= UFP_ST_RUN;
        end
        default:
          st_q <= UFP_ST_RUN;
      endcase
    end
  end

  // ******************************************************************
  // flags
  // ******************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      bus_overcurrent_flag <= 1'b0;
      supply_overcurrent_flag <= 1'b0;
      cc_overvoltage_flag <= 1'b0;
      over_temp_flag <= 1'b0;
      oc_hold_active <= 1'b0;
    end
    else
    begin
      if (st_q == UFP_ST_RUN && bus_oc_ev)
        bus_overcurrent_flag <= 1'b1;
      else if (st_q == UFP_ST_LATCHED && wr_ev_q && is_recovery(wr_byte_q))
        bus_overcurrent_flag <= 1'b0;
      if (st_q == UFP_ST_RUN && sup_oc_ev && !bus_oc_ev)
        supply_overcurrent_flag <= 1'b1;
      else if (st_q == UFP_ST_LATCHED && wr_ev_q && is_recovery(wr_byte_q))
        supply_overcurrent_flag <= 1'b0;
      cc_overvoltage_flag <= cc_ov_s;
      over_temp_flag <= ot_s;
      oc_hold_active <= (st_q == UFP_ST_HOLD);
    end
  end

  // ******************************************************************
  // output stage
  // ******************************************************************
  logic oc_trip;
  logic oc_off;
  logic last_cc2_q;
  // trip cycle already counts as off, so outputs drop on the edge that raises the flag
  assign oc_trip = (st_q == UFP_ST_RUN) && (bus_oc_ev || sup_oc_ev);
  assign oc_off = (st_q != UFP_ST_RUN) || oc_trip || ot_s;

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      last_cc2_q <= 1'b0;
    else if (ctl_q[CTL_SW2_BIT] && !ctl_q[CTL_SW1_BIT] && !oc_off)
      last_cc2_q <= 1'b1;
    else if (ctl_q[CTL_SW1_BIT] && !ctl_q[CTL_SW2_BIT] && !oc_off)
      last_cc2_q <= 1'b0;
  end

  logic sw1;
  logic sw2;
  logic sup_dis;
  logic bus_dis;
  logic err;
  assign sw1 = !oc_off && ctl_q[CTL_SW1_BIT] && !ctl_q[CTL_SW2_BIT];
  assign sw2 = !oc_off && ctl_q[CTL_SW2_BIT] && !ctl_q[CTL_SW1_BIT];
  assign sup_dis = (ctl_q[CTL_SUP_DIS_BIT] || (st_q != UFP_ST_RUN && bus_src_q)) && !sw1 && !sw2;
  assign bus_dis = ctl_q[CTL_BUS_DIS_BIT] || (st_q != UFP_ST_RUN && bus_src_q);
  assign err = (st_q != UFP_ST_RUN) || oc_trip || cc_ov_s || ot_s;

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      cc1_supply_sw_on <= 1'b0;
      cc2_supply_sw_on <= 1'b0;
      provider_gate_on <= 1'b0;
      consumer_gate_on <= 1'b0;
      cc_switch_on <= 1'b0;
      cc_line_protect <= 1'b0;
      bus_discharge_on <= 1'b0;
      cc1_supply_discharge_on <= 1'b0;
      cc2_supply_discharge_on <= 1'b0;
      current_sense_en <= 1'b0;
      supply_soft_start <= 1'b0;
      fault_flag_pin_o <= 1'b0;
      fault_flag_pin_oe <= 1'b0;
    end
    else
    begin
      cc1_supply_sw_on <= sw1;
      cc2_supply_sw_on <= sw2;
      provider_gate_on <= !oc_off && ctl_q[CTL_GDP_BIT];
      consumer_gate_on <= !oc_off && ctl_q[CTL_GDC_BIT];
      // channel switches off during hold, the trip cycle, over-temperature or over-voltage
      cc_switch_on <= (st_q != UFP_ST_HOLD) && !oc_trip && !ot_s && !cc_ov_s;
      cc_line_protect <= cc_ov_s && !ot_s;
      bus_discharge_on <= bus_dis;
      cc1_supply_discharge_on <= sup_dis && !last_cc2_q;
      cc2_supply_discharge_on <= sup_dis && last_cc2_q;
      current_sense_en <= normal;
      supply_soft_start <= soft_q;
      fault_flag_pin_o <= 1'b0;
      if (normal)
        fault_flag_pin_oe <= err;
      else
        fault_flag_pin_oe <= present_s || err;
    end
  end

  // ******************************************************************
  // acknowledge readback
  // ******************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      cc1_supply_switch_ack <= 1'b0;
      cc2_supply_switch_ack <= 1'b0;
      provider_gate_ack <= 1'b0;
      consumer_gate_ack <= 1'b0;
      power_mode_bit_low <= 1'b0;
      power_mode_bit_high <= 1'b0;
      bus_discharge_ack <= 1'b0;
      supply_discharge_ack <= 1'b0;
    end
    else
    begin
      cc1_supply_switch_ack <= sw1;
      cc2_supply_switch_ack <= sw2;
      provider_gate_ack <= !oc_off && ctl_q[CTL_GDP_BIT];
      consumer_gate_ack <= !oc_off && ctl_q[CTL_GDC_BIT];
      power_mode_bit_low <= ctl_q[CTL_PM_LO_BIT];
      power_mode_bit_high <= ctl_q[CTL_PM_HI_BIT];
      bus_discharge_ack <= bus_dis;
      supply_discharge_ack <= sup_dis;
    end
  end

endmodule

/* core/ufp_pkg.sv */
package ufp_pkg;

  // ******************************************************************
  // clock and timing
  // ******************************************************************
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned OC_HOLD_US = 40;
  localparam int unsigned OC_HOLD_CYC = OC_HOLD_US * CLK_MHZ;
  localparam int unsigned SOFT_START_MIN_US = 512;
  localparam int unsigned SOFT_START_MAX_US = 1000;
  localparam int unsigned SOFT_START_CYC = SOFT_START_MIN_US * CLK_MHZ;
  localparam int unsigned CNT_W = 17;

  // ******************************************************************
  // control byte layout
  // ******************************************************************
  localparam int unsigned CTL_SW1_BIT = 0;
  localparam int unsigned CTL_SW2_BIT = 1;
  localparam int unsigned CTL_GDP_BIT = 2;
  localparam int unsigned CTL_GDC_BIT = 3;
  localparam int unsigned CTL_PM_LO_BIT = 4;
  localparam int unsigned CTL_PM_HI_BIT = 5;
  localparam int unsigned CTL_BUS_DIS_BIT = 6;
  localparam int unsigned CTL_SUP_DIS_BIT = 7;
  localparam logic [7:0] RECOVERY_MASK = 8'hcf;
  localparam logic [7:0] RECOVERY_VALUE = 8'h08;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // ******************************************************************
  // power modes and fault state
  // ******************************************************************
  typedef enum logic [1:0]
  {
    UFP_PM_HIBERNATE = 2'b00,
    UFP_PM_LOW_POWER = 2'b01,
    UFP_PM_NORMAL = 2'b10,
    UFP_PM_UNUSED = 2'b11
  } ufp_pm_t;

  typedef enum logic [1:0]
  {
    UFP_ST_RUN = 2'b00,
    UFP_ST_HOLD = 2'b01,
    UFP_ST_LATCHED = 2'b10
  } ufp_state_t;

endpackage

/* test/ufp_fault_checker.sv */
`timescale 1ns/1ps
// ******************************
// fault response port checks
// ******************************
module ufp_fault_checker
#(
  parameter int unsigned HOLD_CYC = 4000
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // comparators
  input wire logic cc_overvoltage,
  input wire logic over_temp,
  // power stage
  input wire logic cc1_supply_sw_on,
  input wire logic cc2_supply_sw_on,
  input wire logic provider_gate_on,
  input wire logic consumer_gate_on,
  input wire logic cc_switch_on,
  input wire logic cc_line_protect,
  input wire logic bus_discharge_on,
  input wire logic cc1_supply_discharge_on,
  input wire logic cc2_supply_discharge_on,
  input wire logic current_sense_en,
  input wire logic fault_flag_pin_oe,
  // status
  input wire logic cc1_supply_switch_ack,
  input wire logic cc2_supply_switch_ack,
  input wire logic power_mode_bit_low,
  input wire logic power_mode_bit_high,
  input wire logic bus_overcurrent_flag,
  input wire logic oc_hold_active
);
  int unsigned hold_cnt_q;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // cycles spent in the current hold
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || !oc_hold_active)
      hold_cnt_q <= 0;
    else
      hold_cnt_q <= hold_cnt_q + 1;
  end
  AST_SENSE_MODE: assert property (current_sense_en |-> power_mode_bit_high && !power_mode_bit_low)
    else $error("sense on outside normal mode");
  AST_OC_SHUT: assert property ($rose(oc_hold_active) |-> ##[0:2] !(cc1_supply_sw_on || cc2_supply_sw_on
    || provider_gate_on || consumer_gate_on || cc_switch_on)) else $error("shutdown missing");
  AST_HOLD_MAX: assert property (hold_cnt_q <= HOLD_CYC + 2)
    else $error("hold too long");
  AST_CC_BACK: assert property ($fell(oc_hold_active) |-> ##[0:2] cc_switch_on && !provider_gate_on)
    else $error("channel switch not back");
  AST_NO_RESTART: assert property (bus_overcurrent_flag |-> !(provider_gate_on || consumer_gate_on))
    else $error("restart while latched");
  AST_FLAG_LATCH: assert property (bus_overcurrent_flag |-> fault_flag_pin_oe)
    else $error("flag pin released early");
  AST_BUS_DISCH: assert property ($rose(bus_overcurrent_flag) |-> ##[0:1] bus_discharge_on)
    else $error("no bus discharge");
  AST_ACK_CLR: assert property ($rose(oc_hold_active) |-> ##[0:2] !(cc1_supply_switch_ack || cc2_supply_switch_ack))
    else $error("ack not cleared");
  AST_VDIS_BLOCK: assert property (!((cc1_supply_sw_on || cc2_supply_sw_on) && (cc1_supply_discharge_on || cc2_supply_discharge_on)))
    else $error("discharge with switch closed");
  AST_OV_PROTECT: assert property ($rose(cc_overvoltage) |-> ##[1:4] cc_line_protect && fault_flag_pin_oe)
    else $error("line protect late");
  AST_OT_SHUT: assert property ($rose(over_temp) |-> ##[1:4] fault_flag_pin_oe && !cc_switch_on)
    else $error("thermal shutdown late");
  cover property ($rose(oc_hold_active));
  cover property ($rose(cc_line_protect));
  cover property ($fell(fault_flag_pin_oe));
endmodule
bind ufp_fault_ctrl ufp_fault_checker #(.HOLD_CYC(HOLD_CYC)) chk_i (.*);

/* test/ufp_fault_ctrl_bench.sv */
`timescale 1ns/1ps
module ufp_fault_ctrl_bench;
  import ufp_pkg::*;
  localparam int unsigned HOLD = 60;
  localparam int unsigned SOFT = 50;
  logic ref_clk, link_clk, resetn, link_resetn, ctl_wr_stb, cc_overvoltage, over_temp, bus_present;
  logic [3:0] cmp;
  logic [7:0] ctl_wr_data;
  logic cc1_supply_sw_on, cc2_supply_sw_on, provider_gate_on, consumer_gate_on, cc_switch_on, cc_line_protect;
  logic bus_discharge_on, cc1_supply_discharge_on, cc2_supply_discharge_on, current_sense_en, supply_soft_start;
  logic fault_flag_pin_o, fault_flag_pin_oe, cc1_supply_switch_ack, cc2_supply_switch_ack, provider_gate_ack;
  logic consumer_gate_ack, power_mode_bit_low, power_mode_bit_high, bus_discharge_ack, supply_discharge_ack;
  logic bus_overcurrent_flag, supply_overcurrent_flag, cc_overvoltage_flag, over_temp_flag, oc_hold_active;
  int unsigned miscompares = 0;
  int unsigned total_checks = 0;
  int unsigned cycles = 0;
  // pulled-up open-drain pin
  wire fault_flag_pin = fault_flag_pin_oe ? fault_flag_pin_o : 1'b1;
  ufp_fault_ctrl #(.HOLD_CYC(HOLD), .SOFT_CYC(SOFT)) uut (.ref_clk(ref_clk), .resetn(resetn), .link_clk(link_clk),
    .link_resetn(link_resetn), .ctl_wr_stb(ctl_wr_stb), .ctl_wr_data(ctl_wr_data), .bus_oc_sink(cmp[0]),
    .bus_oc_source(cmp[1]), .supply_oc_normal(cmp[2]), .supply_oc_soft(cmp[3]), .cc_overvoltage(cc_overvoltage),
    .over_temp(over_temp), .bus_present(bus_present), .cc1_supply_sw_on(cc1_supply_sw_on),
    .cc2_supply_sw_on(cc2_supply_sw_on), .provider_gate_on(provider_gate_on), .consumer_gate_on(consumer_gate_on),
    .cc_switch_on(cc_switch_on), .cc_line_protect(cc_line_protect), .bus_discharge_on(bus_discharge_on),
    .cc1_supply_discharge_on(cc1_supply_discharge_on), .cc2_supply_discharge_on(cc2_supply_discharge_on),
    .current_sense_en(current_sense_en), .supply_soft_start(supply_soft_start), .fault_flag_pin_o(fault_flag_pin_o),
    .fault_flag_pin_oe(fault_flag_pin_oe), .cc1_supply_switch_ack(cc1_supply_switch_ack),
    .cc2_supply_switch_ack(cc2_supply_switch_ack), .provider_gate_ack(provider_gate_ack),
    .consumer_gate_ack(consumer_gate_ack), .power_mode_bit_low(power_mode_bit_low),
    .power_mode_bit_high(power_mode_bit_high), .bus_discharge_ack(bus_discharge_ack),
    .supply_discharge_ack(supply_discharge_ack), .bus_overcurrent_flag(bus_overcurrent_flag),
    .supply_overcurrent_flag(supply_overcurrent_flag), .cc_overvoltage_flag(cc_overvoltage_flag),
    .over_temp_flag(over_temp_flag), .oc_hold_active(oc_hold_active));
  ufp_mcu_model mcu (.link_clk(link_clk), .ctl_wr_stb(ctl_wr_stb), .ctl_wr_data(ctl_wr_data));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    link_resetn = 1'b0;
    #7;
    repeat (6) #32 link_clk = ~link_clk;
    link_resetn = 1'b1;
    forever #32 link_clk = ~link_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      final_report();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // control write, then back onto a falling system clock edge
  task automatic wr(input logic [7:0] b);
    mcu.send(b);
    wt(1);
  endtask
  task automatic pulse(input int k);
    @(negedge ref_clk);
    cmp[k] = 1'b1;
    wt(3);
    cmp[k] = 1'b0;
    wt(4);
  endtask
  task automatic hold_end;
    int n;
    n = 0;
    // firmware waits out the alarm hold
    while (oc_hold_active === 1'b1 && n < 200)
    begin
      wt(1);
      n++;
    end
    chk({7'h0, oc_hold_active}, 8'h00);
    wt(4);
  endtask
  task automatic recover(input logic [1:0] pm);
    wr(mcu.rec_word(pm));
    // the recovery byte lands in the control register: its bit 3 closes the consumer gate
    chk({1'h0, consumer_gate_ack, power_mode_bit_high, power_mode_bit_low, fault_flag_pin, bus_overcurrent_flag,
      supply_overcurrent_flag, consumer_gate_on}, {2'h1, pm, 4'h9});
  endtask
  task automatic t_norm;
    chk({4'h0, cc_switch_on, current_sense_en, fault_flag_pin, cc1_supply_sw_on}, 8'h0a);
    wr(8'h25);
    chk({consumer_gate_ack, provider_gate_ack, cc1_supply_sw_on, provider_gate_on, current_sense_en,
      cc1_supply_switch_ack, power_mode_bit_high, power_mode_bit_low}, 8'h7e);
    $display("normal test done");
  endtask
  task automatic t_bus_oc;
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h25);
      pulse(k);
      chk({oc_hold_active, cc1_supply_sw_on, provider_gate_on, cc_switch_on, fault_flag_pin,
        cc1_supply_switch_ack, bus_overcurrent_flag, bus_discharge_on}, 8'h83);
      chk({7'h0, cc1_supply_discharge_on}, 8'h01);
      wr(mcu.rec_word(2'b10));
      hold_end();
      chk({4'h0, cc_switch_on, cc1_supply_sw_on, provider_gate_on, fault_flag_pin}, 8'h08);
      wr(8'h25);
      chk({4'h0, cc_switch_on, cc1_supply_sw_on, provider_gate_on, fault_flag_pin}, 8'h08);
      recover(2'b10);
    end
    $display("bus oc test done");
  endtask
  task automatic t_sup_oc;
    wr(8'h22);
    chk({6'h0, supply_soft_start, cc2_supply_sw_on}, 8'h03);
    pulse(2);
    chk({7'h0, oc_hold_active}, 8'h00);
    wt(SOFT);
    chk({7'h0, supply_soft_start}, 8'h00);
    // raised comparator no longer counts once soft start is over
    pulse(3);
    chk({7'h0, oc_hold_active}, 8'h00);
    pulse(2);
    chk({4'h0, oc_hold_active, cc2_supply_switch_ack, supply_overcurrent_flag, bus_discharge_on}, 8'h0a);
    hold_end();
    recover(2'b10);
    $display("supply oc test done");
  endtask
  task automatic t_low;
    wr(8'h15);
    bus_present = 1'b1;
    pulse(1);
    chk({5'h0, oc_hold_active, current_sense_en, fault_flag_pin}, 8'h00);
    bus_present = 1'b0;
    wt(5);
    chk({7'h0, fault_flag_pin}, 8'h01);
    $display("low power test done");
  endtask
  task automatic t_ov_ot;
    wr(8'h25);
    cc_overvoltage = 1'b1;
    wt(6);
    chk({4'h0, cc_line_protect, fault_flag_pin, cc_switch_on, cc_overvoltage_flag}, 8'h09);
    cc_overvoltage = 1'b0;
    wt(6);
    chk({4'h0, cc_line_protect, fault_flag_pin, cc_switch_on, cc_overvoltage_flag}, 8'h06);
    over_temp = 1'b1;
    wt(6);
    chk({3'h0, cc1_supply_sw_on, provider_gate_on, cc_switch_on, fault_flag_pin, over_temp_flag}, 8'h01);
    over_temp = 1'b0;
    wt(6);
    chk({3'h0, cc1_supply_sw_on, provider_gate_on, cc_switch_on, fault_flag_pin, over_temp_flag}, 8'h1e);
    $display("ov ot test done");
  endtask
  task automatic t_dis;
    wr(8'ha2);
    chk({5'h0, cc2_supply_sw_on, cc1_supply_discharge_on, cc2_supply_discharge_on}, 8'h04);
    wr(8'hc0);
    chk({3'h0, cc1_supply_discharge_on, cc2_supply_discharge_on, bus_discharge_on, bus_discharge_ack,
      supply_discharge_ack}, 8'h0f);
    wr(8'h00);
    chk({6'h0, bus_discharge_on, cc2_supply_discharge_on}, 8'h00);
    $display("discharge test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    resetn = 1'b0;
    cmp = 4'h0;
    cc_overvoltage = 1'b0;
    over_temp = 1'b0;
    bus_present = 1'b0;
    repeat (3) @(negedge ref_clk);
    resetn = 1'b1;
    wait (link_resetn === 1'b1);
    wt(4);
    t_norm();
    t_bus_oc();
    t_sup_oc();
    t_low();
    t_ov_ot();
    t_dis();
    final_report();
  end
endmodule

/* test/ufp_mcu_model.sv */
`timescale 1ns/1ps
module ufp_mcu_model
(
  // link side
  input wire logic link_clk,
  output logic ctl_wr_stb,
  output logic [7:0] ctl_wr_data
);
  initial
  begin
    ctl_wr_stb = 1'b0;
    ctl_wr_data = 8'h00;
  end
  // one plain control write, then spacing
  task automatic send(input logic [7:0] b);
    @(negedge link_clk);
    ctl_wr_stb = 1'b1;
    ctl_wr_data = b;
    @(negedge link_clk);
    ctl_wr_stb = 1'b0;
    ctl_wr_data = ~b;
    repeat (4) @(negedge link_clk);
  endtask
  function automatic logic [7:0] rec_word(input logic [1:0] pm);
    return {2'b00, pm, 4'h8};
  endfunction
endmodule
